// *** frame_policy_cfg.svh ***
// constants for the global frame policy register bank
// assumes an 8-bit register address space, one byte per register
`ifndef FRAME_POLICY_CFG_SVH
`define FRAME_POLICY_CFG_SVH

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define POLICY_CTRL_OFFSET      8'h04
`define FORWARD_OPT_OFFSET      8'h05

// --------------------------------------------------------------
// frame policy control fields
// --------------------------------------------------------------
`define PC_VLAN_DISCARD_BIT     7
`define PC_MCAST_EXCL_BIT       6
`define PC_BP_CARRIER_BIT       5
`define PC_FAIR_BIT             4
`define PC_COL_KEEP_BIT         3
`define PC_HUGE_BIT             2
`define PC_LEN_CHECK_DIS_BIT    1
`define POLICY_CTRL_RESET       8'hf0
`define POLICY_CTRL_WMASK       8'hfe

// --------------------------------------------------------------
// forwarding options fields
// --------------------------------------------------------------
`define FO_VLAN_EN_BIT          7
`define FO_IGMP_SNOOP_BIT       6
`define FO_DIRECT_BIT           5
`define FO_PRETAG_BIT           4
`define FO_TAG_MASK_BIT         1
`define FO_SNIFF_AND_BIT        0
`define FORWARD_OPT_RESET       8'h00
`define FORWARD_OPT_WMASK       8'hf3

// --------------------------------------------------------------
// frame limits and unmapped read value
// --------------------------------------------------------------
`define LEN_HUGE_MAX            11'h77c
`define LEN_RELAXED_MAX         11'h600
`define LEN_TAGGED_MAX          11'h5f2
`define LEN_UNTAGGED_MAX        11'h5ee
`define EXCESS_COLLISIONS       5'h10
`define UNMAPPED_READ           8'h00

`endif

// *** frame_policy_pkg.sv ***
// types shared by the frame policy register bank
// assumes the forwarding engine fills a frame query per frame
package frame_policy_pkg;

    // --------------------------------------------------------------
    // one frame to be judged
    // --------------------------------------------------------------
    typedef struct packed {
        logic        known_unicast;    // known unicast destination
        logic        is_multicast;     // multicast destination
        logic        is_broadcast;     // all-ones destination
        logic        crosses_vlan;     // leaves source port vlan
        logic        is_tagged;        // carries a vlan tag
        logic        special_cpu_tag;  // special_cpu_tag_id to ports 1-4
        logic [10:0] frame_len;        // length in bytes
        logic [4:0]  collisions;       // collisions seen so far
        logic        is_igmp;          // igmp frame
        logic [11:0] vid;              // frame vid
        logic        src_sniff_hit;    // source port is sniffed
        logic        dst_sniff_hit;    // destination port is sniffed
        logic        fc_contention;    // flow-ctl and non-flow-ctl share dest
        logic        from_host;        // received on host_mac_port
        logic        directive_valid;  // preamble directive seen
        logic [4:0]  directive_mask;   // ports named by the directive
        logic        to_host;          // leaves on host_mac_port
        logic [2:0]  src_port;         // ingress port number
    } frame_query_t;

    // --------------------------------------------------------------
    // verdict for one frame
    // --------------------------------------------------------------
    typedef struct packed {
        logic        vlan_block;       // stop at vlan boundary
        logic        storm_count;      // counts toward storm limit
        logic        drop_nonfc;       // drop from non-flow-ctl source
        logic        throttle_fc;      // throttle flow-ctl source
        logic        drop_collision;   // excessive collision drop
        logic        drop_oversize;    // too long for current limit
        logic        igmp_to_host;     // send copy to host port
        logic        bypass_lookup;    // direct mode forwarding
        logic        use_port_mask;    // mask overrides lookup
        logic [4:0]  port_mask;        // destination ports
        logic        mirror;           // copy to sniffer
        logic        pretag_valid;     // put source in preamble
        logic [2:0]  pretag_src;       // source port for the preamble
    } frame_verdict_t;

    // --------------------------------------------------------------
    // static settings seen by the mac and engine
    // --------------------------------------------------------------
    typedef struct packed {
        logic bp_carrier_sense;        // else collision based
        logic fair_mode;               // fairness between sources
        logic vlan_enable;             // tagged vlan mode
        logic direct_mode;             // host directs forwarding
        logic pretag_enable;           // host frames pre-tagged
    } policy_view_t;

endpackage : frame_policy_pkg

// *** switch_global_frame_policy_regs.sv ***
// global frame policy registers and the per-frame verdict logic
// assumes the register port and frame query are synchronous to REF_CLK
//
// Function
// - cleared discard lets known unicast cross vlans
// - set discard blocks every frame crossing vlans
// - storm counts broadcast, multicast only when cleared
// - back pressure carrier-sense when set, else collision
// - fair mode drops non-flow-controlled source frames
// - unfair mode throttles the flow-controlled source
// - keep bit stops sixteen-collision frame drop
// - huge bit allows 1916 bytes, overrides check
// - check disable allows 1536 bytes otherwise
// - default limits 1522 tagged, 1536 tagged with special cpu tag, 1518 untagged
// - vlan enable bit turns on tagged vlan
// - igmp snooping forwards igmp frames to host
// - direct mode forwards per preamble, no lookup
// - pre-tag marks host-bound frames with source
// - tag mask uses vid low bits, vlan off
// - sniff and-mode needs both ports matching
`include "frame_policy_cfg.svh"

module switch_global_frame_policy_regs
    import frame_policy_pkg::*;
(
    input  wire logic           REF_CLK,
    input  wire logic           NRST,
    input  wire logic [7:0]     REG_ADDR,
    input  wire logic           REG_WR,
    input  wire logic [7:0]     REG_WDATA,
    output logic      [7:0]     REG_RDATA,
    input  wire logic           COLLISION_POLICY_STRAP_PIN,
    input  wire logic           QRY_VALID,
    input  wire frame_query_t   QRY,
    output logic                VRD_VALID,
    output frame_verdict_t      VRD,
    output policy_view_t        POLICY
);

    // --------------------------------------------------------------
    // register state
    // --------------------------------------------------------------
    logic [7:0]     policy_ctrl_reg;    // frame policy control
    logic [7:0]     policy_ctrl_next;
    logic [7:0]     fwd_opt_reg;        // forwarding options
    logic [7:0]     fwd_opt_next;
    logic [7:0]     rdata_reg;          // registered read data
    logic [7:0]     rdata_next;
    logic           strap_done_reg;     // strap already sampled
    logic           strap_done_next;

    // next register values; strap is taken on the first edge after
    // release, since an async reset may only load constants
    always_comb
    begin
        policy_ctrl_next = policy_ctrl_reg;
        fwd_opt_next     = fwd_opt_reg;
        strap_done_next  = 1'b1;
        // collision keep default follows the strap
        if (!strap_done_reg)
        begin
            policy_ctrl_next[`PC_COL_KEEP_BIT] = COLLISION_POLICY_STRAP_PIN;
        end
        // writes; reserved and foreign bits stay zero
        if (REG_WR && (REG_ADDR == `POLICY_CTRL_OFFSET))
        begin
            policy_ctrl_next = REG_WDATA & `POLICY_CTRL_WMASK;
        end
        else if (REG_WR && (REG_ADDR == `FORWARD_OPT_OFFSET))
        begin
            fwd_opt_next = REG_WDATA & `FORWARD_OPT_WMASK;
        end
        // read decode, unmapped reads zero
        case (REG_ADDR)
            `POLICY_CTRL_OFFSET: rdata_next = policy_ctrl_reg;
            `FORWARD_OPT_OFFSET: rdata_next = fwd_opt_reg;
            default:             rdata_next = `UNMAPPED_READ;
        endcase
    end

    // register update
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            policy_ctrl_reg <= `POLICY_CTRL_RESET;
            fwd_opt_reg     <= `FORWARD_OPT_RESET;
            rdata_reg       <= `UNMAPPED_READ;
            strap_done_reg  <= 1'b0;
        end
        else
        begin
            policy_ctrl_reg <= policy_ctrl_next;
            fwd_opt_reg     <= fwd_opt_next;
            rdata_reg       <= rdata_next;
            strap_done_reg  <= strap_done_next;
        end
    end

    assign REG_RDATA = rdata_reg;

    // --------------------------------------------------------------
    // decoded settings
    // --------------------------------------------------------------
    logic           vlan_discard;       // strict vlan boundary
    logic           mcast_excl;         // storm ignores multicast
    logic           fair_mode;          // fairness selected
    logic           col_keep;           // keep excessive collisions
    logic           huge_en;            // huge frames allowed
    logic           len_check_dis;      // relaxed length check
    logic           vlan_en;            // tagged vlan mode
    logic           tag_mask_en;        // vid mask requested
    logic           sniff_and;          // both ports must match

    assign vlan_discard  = policy_ctrl_reg[`PC_VLAN_DISCARD_BIT];
    assign mcast_excl    = policy_ctrl_reg[`PC_MCAST_EXCL_BIT];
    assign fair_mode     = policy_ctrl_reg[`PC_FAIR_BIT];
    assign col_keep      = policy_ctrl_reg[`PC_COL_KEEP_BIT];
    assign huge_en       = policy_ctrl_reg[`PC_HUGE_BIT];
    assign len_check_dis = policy_ctrl_reg[`PC_LEN_CHECK_DIS_BIT];
    assign vlan_en       = fwd_opt_reg[`FO_VLAN_EN_BIT];
    assign tag_mask_en   = fwd_opt_reg[`FO_TAG_MASK_BIT];
    assign sniff_and     = fwd_opt_reg[`FO_SNIFF_AND_BIT];

    // static settings for the mac and engine
    always_comb
    begin
        POLICY.bp_carrier_sense = policy_ctrl_reg[`PC_BP_CARRIER_BIT];
        POLICY.fair_mode        = fair_mode;
        POLICY.vlan_enable      = vlan_en;
        POLICY.direct_mode      = fwd_opt_reg[`FO_DIRECT_BIT];
        POLICY.pretag_enable    = fwd_opt_reg[`FO_PRETAG_BIT];
    end

    // --------------------------------------------------------------
    // per-frame verdict
    // --------------------------------------------------------------
    frame_verdict_t vrd_reg;            // registered verdict
    frame_verdict_t vrd_next;
    logic           vrd_valid_reg;      // verdict strobe
    logic           vrd_valid_next;
    logic [10:0]    len_limit;          // length limit for this frame

    // verdict computed from the query and the current settings
    always_comb
    begin
        vrd_next       = vrd_reg;
        vrd_valid_next = QRY_VALID;
        len_limit      = `LEN_UNTAGGED_MAX;
        // huge limit wins over the check disable
        if (huge_en)
        begin
            len_limit = `LEN_HUGE_MAX;
        end
        else if (len_check_dis)
        begin
            len_limit = `LEN_RELAXED_MAX;
        end
        else if (QRY.is_tagged && QRY.special_cpu_tag)
        begin
            len_limit = `LEN_RELAXED_MAX;
        end
        else if (QRY.is_tagged)
        begin
            len_limit = `LEN_TAGGED_MAX;
        end
        if (QRY_VALID)
        begin
            vrd_next.vlan_block     = QRY.crosses_vlan && (vlan_discard || !QRY.known_unicast);
            vrd_next.storm_count    = QRY.is_broadcast || (QRY.is_multicast && !mcast_excl);
            vrd_next.drop_nonfc     = QRY.fc_contention && fair_mode;
            vrd_next.throttle_fc    = QRY.fc_contention && !fair_mode;
            vrd_next.drop_collision = (QRY.collisions >= `EXCESS_COLLISIONS) && !col_keep;
            vrd_next.drop_oversize  = QRY.frame_len > len_limit;
            vrd_next.igmp_to_host   = fwd_opt_reg[`FO_IGMP_SNOOP_BIT] && QRY.is_igmp;
            vrd_next.bypass_lookup  = fwd_opt_reg[`FO_DIRECT_BIT] && QRY.from_host && QRY.directive_valid;
            // vid mask only without tagged vlan
            vrd_next.use_port_mask  = vrd_next.bypass_lookup || (tag_mask_en && !vlan_en);
            vrd_next.port_mask      = vrd_next.bypass_lookup ? QRY.directive_mask : QRY.vid[4:0];
            vrd_next.mirror         = sniff_and ? (QRY.src_sniff_hit && QRY.dst_sniff_hit)
                                                : (QRY.src_sniff_hit || QRY.dst_sniff_hit);
            vrd_next.pretag_valid   = fwd_opt_reg[`FO_PRETAG_BIT] && QRY.to_host;
            vrd_next.pretag_src     = QRY.src_port;
        end
    end

    // verdict registers
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            vrd_reg       <= '0;
            vrd_valid_reg <= 1'b0;
        end
        else
        begin
            vrd_reg       <= vrd_next;
            vrd_valid_reg <= vrd_valid_next;
        end
    end

    assign VRD       = vrd_reg;
    assign VRD_VALID = vrd_valid_reg;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_unicast_cross;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && QRY.crosses_vlan && QRY.known_unicast && !vlan_discard |=> VRD_VALID && !VRD.vlan_block;
    endproperty
    a_unicast_cross: assert property (p_unicast_cross) else $error("known unicast blocked");

    property p_strict_vlan;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && QRY.crosses_vlan && vlan_discard |=> VRD.vlan_block;
    endproperty
    a_strict_vlan: assert property (p_strict_vlan) else $error("vlan crossing not blocked");

    property p_storm;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && QRY.is_multicast && !QRY.is_broadcast |=> VRD.storm_count == !$past(mcast_excl);
    endproperty
    a_storm: assert property (p_storm) else $error("multicast storm scope wrong");

    property p_bp_style;
        @(posedge REF_CLK) disable iff (!NRST)
        REG_WR && REG_ADDR == `POLICY_CTRL_OFFSET |=> POLICY.bp_carrier_sense == $past(REG_WDATA[`PC_BP_CARRIER_BIT]);
    endproperty
    a_bp_style: assert property (p_bp_style) else $error("back pressure style not updated");

    property p_fairness;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && QRY.fc_contention |=> (VRD.drop_nonfc ^ VRD.throttle_fc) && VRD.drop_nonfc == $past(fair_mode);
    endproperty
    a_fairness: assert property (p_fairness) else $error("fairness verdict wrong");

    property p_collision;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && QRY.collisions >= `EXCESS_COLLISIONS |=> VRD.drop_collision != $past(col_keep);
    endproperty
    a_collision: assert property (p_collision) else $error("excessive collision verdict wrong");

    property p_huge;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && huge_en |=> VRD.drop_oversize == ($past(QRY.frame_len) > `LEN_HUGE_MAX);
    endproperty
    a_huge: assert property (p_huge) else $error("huge limit wrong");

    property p_relaxed;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && !huge_en && len_check_dis |=> VRD.drop_oversize == ($past(QRY.frame_len) > `LEN_RELAXED_MAX);
    endproperty
    a_relaxed: assert property (p_relaxed) else $error("relaxed limit wrong");

    property p_default_len;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && !huge_en && !len_check_dis && !QRY.is_tagged
        |=> VRD.drop_oversize == ($past(QRY.frame_len) > `LEN_UNTAGGED_MAX);
    endproperty
    a_default_len: assert property (p_default_len) else $error("untagged limit wrong");

    property p_igmp;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && QRY.is_igmp |=> VRD.igmp_to_host == $past(fwd_opt_reg[`FO_IGMP_SNOOP_BIT]);
    endproperty
    a_igmp: assert property (p_igmp) else $error("igmp snooping verdict wrong");

    property p_direct;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && POLICY.direct_mode && QRY.from_host && QRY.directive_valid
        |=> VRD.bypass_lookup && VRD.port_mask == $past(QRY.directive_mask);
    endproperty
    a_direct: assert property (p_direct) else $error("direct forwarding wrong");

    property p_tag_mask;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && vlan_en && !(POLICY.direct_mode && QRY.from_host && QRY.directive_valid)
        |=> !VRD.use_port_mask;
    endproperty
    a_tag_mask: assert property (p_tag_mask) else $error("tag mask active in vlan mode");

    property p_sniff_and;
        @(posedge REF_CLK) disable iff (!NRST)
        QRY_VALID && sniff_and && (QRY.src_sniff_hit != QRY.dst_sniff_hit) |=> !VRD.mirror;
    endproperty
    a_sniff_and: assert property (p_sniff_and) else $error("and-mode sniff mirrored one side");

endmodule : switch_global_frame_policy_regs

// *** host_mac_model.sv ***
// host processor mac on host_mac_port: supplies the preamble directive side
// assumes the bench folds these outputs into each frame query it sends
module host_mac_model
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    output logic            host_frame,
    output logic            directive_valid,
    output logic [4:0]      directive_mask
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] lfsr_reg;   // pattern source
    logic [15:0] lfsr_next;  // next pattern

    // ------------------------------------------------------------
    // pattern that changes every cycle, so no stale directive lingers
    // ------------------------------------------------------------
    always_comb
    begin
        lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lfsr_reg <= 16'hace1;
        else
            lfsr_reg <= lfsr_next;
    end

    assign host_frame      = lfsr_reg[0];
    assign directive_valid = lfsr_reg[1];
    assign directive_mask  = lfsr_reg[6:2];
endmodule : host_mac_model

// *** tb_switch_global_frame_policy_regs.sv ***
// self-checking bench for the global frame policy register bank
// assumes one clock; queries and register writes never overlap
`include "frame_policy_cfg.svh"

module tb_switch_global_frame_policy_regs
    import frame_policy_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           ref_clk, nrst, reg_wr, strap, qry_valid, vrd_valid;
    logic           host_frame, dir_valid, chk_on, chk_pend;
    logic [7:0]     reg_addr, reg_wdata, reg_rdata, pc_sh, fo_sh;
    logic [4:0]     dir_mask;
    frame_query_t   qry;
    frame_verdict_t vrd, chk_exp;
    policy_view_t   policy;
    int             error_cnt, tests_run, seed, i;
    logic [10:0]    len_tab [8] = '{11'h5ee, 11'h5ef, 11'h5f2, 11'h5f3, 11'h600, 11'h601, 11'h77c, 11'h77d};

    switch_global_frame_policy_regs dut (.REF_CLK(ref_clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .COLLISION_POLICY_STRAP_PIN(strap), .QRY_VALID(qry_valid),
        .QRY(qry), .VRD_VALID(vrd_valid), .VRD(vrd), .POLICY(policy));
    host_mac_model partner (.clk(ref_clk), .rst_n(nrst), .host_frame(host_frame), .directive_valid(dir_valid),
        .directive_mask(dir_mask));

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // report and compare helpers
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic cmp_reg(string what, logic [7:0] exp, logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_reg

    task automatic cmp_vrd(frame_verdict_t exp, frame_verdict_t got);
        tests_run++;
        // fields with no meaning while unused are not compared
        got = masked(got, exp);
        exp = masked(exp, exp);
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED verdict expected %h seen %h", exp, got);
        end
    endtask : cmp_vrd

    task automatic cmp_pol(policy_view_t exp, policy_view_t got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED policy expected %h seen %h", exp, got);
        end
    endtask : cmp_pol

    // ------------------------------------------------------------
    // expected verdict from the shadow registers
    // ------------------------------------------------------------
    function automatic frame_verdict_t expect_vrd(frame_query_t q);
        frame_verdict_t v;
        logic [10:0]    lim;
        v   = '0;
        lim = pc_sh[2] ? `LEN_HUGE_MAX : pc_sh[1] ? `LEN_RELAXED_MAX : (q.is_tagged && q.special_cpu_tag) ?
              `LEN_RELAXED_MAX : q.is_tagged ? `LEN_TAGGED_MAX : `LEN_UNTAGGED_MAX;
        v.vlan_block     = q.crosses_vlan && (pc_sh[7] || !q.known_unicast);
        v.storm_count    = q.is_broadcast || (q.is_multicast && !pc_sh[6]);
        v.drop_nonfc     = q.fc_contention && pc_sh[4];
        v.throttle_fc    = q.fc_contention && !pc_sh[4];
        v.drop_collision = (q.collisions >= `EXCESS_COLLISIONS) && !pc_sh[3];
        v.drop_oversize  = q.frame_len > lim;
        v.igmp_to_host   = q.is_igmp && fo_sh[6];
        v.bypass_lookup  = fo_sh[5] && q.from_host && q.directive_valid;
        v.use_port_mask  = v.bypass_lookup || (fo_sh[1] && !fo_sh[7]);
        v.port_mask      = v.bypass_lookup ? q.directive_mask : q.vid[4:0];
        v.mirror         = fo_sh[0] ? (q.src_sniff_hit && q.dst_sniff_hit) : (q.src_sniff_hit || q.dst_sniff_hit);
        v.pretag_valid   = fo_sh[4] && q.to_host;
        v.pretag_src     = q.src_port;
        return v;
    endfunction : expect_vrd

    // fields with no meaning while unused are not compared
    function automatic frame_verdict_t masked(frame_verdict_t v, frame_verdict_t e);
        v.port_mask  = e.use_port_mask ? v.port_mask : 5'h00;
        v.pretag_src = e.pretag_valid ? v.pretag_src : 3'h0;
        return v;
    endfunction : masked

    // random frame, lengths often pinned to a limit or one past it
    function automatic frame_query_t rand_q();
        logic [63:0]  r;
        frame_query_t q;
        r = {$random(seed), $random(seed)};
        q = r[$bits(frame_query_t)-1:0];
        if (r[63])
            q.frame_len = len_tab[r[62:60]];
        q.from_host       = host_frame;
        q.directive_valid = dir_valid;
        q.directive_mask  = dir_mask;
        return q;
    endfunction : rand_q

    // ------------------------------------------------------------
    // drivers: each starts and ends just after a rising edge
    // ------------------------------------------------------------
    task automatic do_reset(logic s);
        chk_on = 1'b0;
        nrst  <= 1'b0;
        strap <= s;
        repeat (3) @(posedge ref_clk);
        nrst  <= 1'b1;
        @(posedge ref_clk);
        pc_sh = `POLICY_CTRL_RESET | {4'h0, s, 3'h0};
        fo_sh = `FORWARD_OPT_RESET;
    endtask : do_reset

    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (a == `POLICY_CTRL_OFFSET)
            pc_sh = d & `POLICY_CTRL_WMASK;
        if (a == `FORWARD_OPT_OFFSET)
            fo_sh = d & `FORWARD_OPT_WMASK;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(logic [7:0] a, logic [7:0] exp);
        reg_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        cmp_reg("register read", exp, reg_rdata);
        @(posedge ref_clk);
    endtask : rd

    // back-to-back queries keep the strobe high between calls
    task automatic send(frame_query_t q);
        frame_verdict_t e;
        e = expect_vrd(q);
        qry       <= q;
        qry_valid <= 1'b1;
        @(posedge ref_clk);
        chk_exp  <= e;
        chk_pend <= 1'b1;
    endtask : send

    task automatic idle;
        qry_valid <= 1'b0;
        @(posedge ref_clk);
        chk_pend <= 1'b0;
    endtask : idle

    // verdict and settings looked at mid-cycle, once settled
    always @(negedge ref_clk)
    begin
        if (chk_on)
        begin
            cmp_reg("verdict strobe", {7'h00, chk_pend}, {7'h00, vrd_valid});
            cmp_pol({pc_sh[5], pc_sh[4], fo_sh[7], fo_sh[5], fo_sh[4]}, policy);
            if (chk_pend)
                cmp_vrd(chk_exp, vrd);
        end
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        strap = 1'b0;
        qry_valid = 1'b0;
        qry = '0;
        chk_on = 1'b0;
        chk_pend = 1'b0;
        chk_exp = '0;
        error_cnt = 0;
        tests_run = 0;
        seed = 32'hf708694a;
        do_reset(1'b0);
        rd(`POLICY_CTRL_OFFSET, 8'hf0);
        rd(`FORWARD_OPT_OFFSET, 8'h00);
        wr(8'h06, 8'hff);
        rd(8'h06, `UNMAPPED_READ);
        wr(`POLICY_CTRL_OFFSET, 8'hff);
        rd(`POLICY_CTRL_OFFSET, 8'hfe);
        wr(`FORWARD_OPT_OFFSET, 8'hff);
        rd(`FORWARD_OPT_OFFSET, 8'hf3);
        chk_on = 1'b1;
        for (i = 0; i < 48; i++)
        begin
            wr(`POLICY_CTRL_OFFSET, 8'($random(seed)));
            wr(`FORWARD_OPT_OFFSET, 8'($random(seed)));
            repeat (8) send(rand_q());
            idle();
        end
        do_reset(1'b1);
        rd(`POLICY_CTRL_OFFSET, 8'hf8);
        wrap_up();
    end
endmodule : tb_switch_global_frame_policy_regs
